// ---- logic/ssr_seq.sv ----
/*
  Scan sequencer with circular reading store and single-channel
  monitor, reached over a classic Wishbone slave.
  Assumes a measurement engine that answers each meas_req_o with one
  meas_valid_i pulse, and an asynchronous external trigger pin.
*/
`include "ssr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ssr_seq
  import ssr_pkg::*;
#(
  parameter int MS_CYC = `SSR_MS_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_trig_i,
  input  wire logic        dmm_ok_i,
  input  wire logic [9:0]  front_chan_i,
  input  wire logic        meas_valid_i,
  input  wire ssr_rdg_s    meas_rdg_i,
  output logic             meas_req_o,
  output logic      [9:0]  meas_chan_o,
  output logic             tot_keep_o,
  output logic             relay_close_o,
  output logic             scan_run_o
);

  ssr_state_s s;
  ssr_state_s n;
  ssr_rdg_s   mem [0:`SSR_MEM_DEPTH-1];
  logic [9:0] list [0:`SSR_LIST_MAX-1];
  logic       mem_we;
  logic       list_we;
  logic       erase;
  logic       ext_edge;
  logic       ms;
  logic       fire;
  logic       mon_ok;
  logic       in_list;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [9:0] mon_chan;
  logic [15:0] rptr;
  logic [16:0] cnt_t;
  logic [31:0] wm;

  function automatic logic [15:0] wrap(input logic [16:0] x);
    wrap = (x >= `SSR_MEM_DEPTH) ? 16'(x - `SSR_MEM_DEPTH) : x[15:0];
  endfunction

  function automatic logic [2:0] ndig(input logic [19:0] v);
    logic [2:0]  r;
    logic [19:0] t;
    r = 3'h1;
    t = v;
    for (int i = 0; i < 5; i++) begin
      if (t > 20'h0_0009) begin
        t = t / 20'h0_000A;
        r = r + 3'h1;
      end
    end
    ndig = r;
  endfunction

  function automatic logic [7:0] digit(input logic [19:0] v, input logic [2:0] k);
    logic [19:0] t;
    t = v;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < k) begin
        t = t / 20'h0_000A;
      end
    end
    digit = `SSR_CH_ZERO + 8'(t % 20'h0_000A);
  endfunction

  assign wb_dat_o      = s.dat;
  assign wb_ack_o      = s.ack;
  assign meas_req_o    = s.mreq;
  assign meas_chan_o   = s.chan;
  assign tot_keep_o    = s.is_mon;
  assign relay_close_o = s.rly;
  assign scan_run_o    = s.run;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.mreq = 1'b0;
    mem_we = 1'b0;
    list_we = 1'b0;
    erase = 1'b0;
    wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Filter accepts a level only once the last two stages agree
    n.sync = {s.sync[1:0], ext_trig_i};
    if (s.sync[1] == s.sync[2]) begin
      n.trg_lvl = s.sync[2];
    end
    ext_edge = n.trg_lvl & ~s.trg_lvl;
    ms = (s.tick == 17'(MS_CYC - 1));
    n.tick = ms ? 17'h0_0000 : s.tick + 17'h0_0001;
    if (ms && s.ivl_cnt != 29'h0) begin
      n.ivl_cnt = s.ivl_cnt - 29'h1;
    end
    mon_chan = s.moncfg[`SSR_M_SEL] ? s.moncfg[9:0] : front_chan_i;
    in_list = 1'b0;
    for (int i = 0; i < `SSR_LIST_MAX; i++) begin
      if (7'(i) < s.size && list[i] == mon_chan) begin
        in_list = 1'b1;
      end
    end
    mon_ok = s.moncfg[`SSR_M_EN] &&
             (s.moncfg[11:10] != K_MUX || (dmm_ok_i && in_list));
    acc = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = acc & wb_we_i;
    rd = acc & ~wb_we_i;
    n.ack = acc;
    n.dat = 32'h0000_0000;
    rptr = (wb_adr_i[5:2] == `SSR_A_FETCH) ? wrap(17'(s.tail) + s.fidx) : s.tail;
    if (wr) begin
      case (wb_adr_i[5:2])
        `SSR_A_CTRL: begin
          if (wb_sel_i[0] && wb_dat_i[`SSR_C_TRIG] && s.run) begin
            n.pend = 1'b1;
          end
          // Software clear loses to a fresh overflow below
          if (wb_sel_i[0] && wb_dat_i[`SSR_C_OVFCLR]) begin
            n.ovf = 1'b0;
          end
        end
        `SSR_A_SRC:   n.src = ssr_src_e'((s.src & ~wm[1:0]) | (wb_dat_i[1:0] & wm[1:0]));
        `SSR_A_IVL:   n.ivl = (s.ivl & ~wm[28:0]) | (wb_dat_i[28:0] & wm[28:0]);
        `SSR_A_COUNT: begin
          n.cnt_set = (s.cnt_set & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
          if (wb_sel_i[3]) begin
            n.cnt_inf = wb_dat_i[`SSR_N_INF];
          end
        end
        `SSR_A_DELAY: n.dly_set = (s.dly_set & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `SSR_A_LIST: begin
          // Empty list clears; list frozen while scanning
          if (!s.run && wb_dat_i[`SSR_L_CLR]) begin
            n.size = 7'h00;
          end else if (!s.run && s.size < `SSR_LIST_MAX) begin
            list_we = 1'b1;
            n.size = s.size + 7'h01;
          end
        end
        `SSR_A_LISTQ:  n.lpos = 7'h00;
        `SSR_A_FETCH:  n.fidx = 17'h0_0000;
        `SSR_A_DRAIN:  n.rdlim = (wb_dat_i[16:0] == 17'h0_0000) ? `SSR_MEM_DEPTH : wb_dat_i[16:0];
        `SSR_A_BLK: begin
          n.blen = wb_dat_i[19:0];
          n.bpos = 3'h0;
        end
        `SSR_A_MONCFG: n.moncfg = (s.moncfg & ~wm[16:0]) | (wb_dat_i[16:0] & wm[16:0]);
        default: ;
      endcase
    end
    if (rd) begin
      case (wb_adr_i[5:2])
        `SSR_A_CTRL:  n.dat = {30'h0, s.st};
        `SSR_A_SRC:   n.dat = {30'h0, s.src};
        `SSR_A_IVL:   n.dat = {3'h0, s.ivl};
        `SSR_A_COUNT: n.dat = s.cnt_inf ? `SSR_CNT_INF_RD : {16'h0000, s.cnt_set};
        `SSR_A_DELAY: n.dat = {16'h0000, s.dly_set};
        `SSR_A_LIST:  n.dat = {25'h0, s.size};
        `SSR_A_LISTQ: begin
          if (s.size == 7'h00) begin
            case (s.lpos)
              7'h00:   n.dat = {24'h0, `SSR_CH_HASH};
              7'h01:   n.dat = {24'h0, `SSR_CH_ONE};
              7'h02:   n.dat = {24'h0, `SSR_CH_THREE};
              7'h03:   n.dat = {24'h0, `SSR_CH_OPEN};
              7'h04:   n.dat = {24'h0, `SSR_CH_AT};
              7'h05:   n.dat = {24'h0, `SSR_CH_CLOSE};
              default: n.dat = 32'h0000_0000;
            endcase
          end else if (s.lpos < s.size) begin
            n.dat = {22'h0, list[s.lpos]};
          end
          if (s.lpos != 7'h7F) begin
            n.lpos = s.lpos + 7'h01;
          end
        end
        `SSR_A_POINTS: n.dat = {15'h0, s.count};
        `SSR_A_FETCH: begin
          if (s.fidx < s.count) begin
            n.dat = {1'b1, 1'b0, mem[rptr].alarm, 4'h0, mem[rptr].value};
            n.fidx = s.fidx + 17'h0_0001;
          end
        end
        `SSR_A_REMOVE: begin
          if (s.count != 17'h0_0000) begin
            n.dat = {1'b1, 1'b0, mem[rptr].alarm, 4'h0, mem[rptr].value};
            erase = 1'b1;
          end
        end
        `SSR_A_DRAIN: begin
          if (s.count != 17'h0_0000 && s.rdlim != 17'h0_0000) begin
            n.dat = {1'b1, 1'b0, mem[rptr].alarm, 4'h0, mem[rptr].value};
            erase = 1'b1;
            n.rdlim = s.rdlim - 17'h0_0001;
          end
        end
        `SSR_A_BLK: begin
          if (s.bpos == 3'h0) begin
            n.dat = {24'h0, `SSR_CH_HASH};
          end else if (s.bpos == 3'h1) begin
            n.dat = {24'h0, `SSR_CH_ZERO + {5'h0, ndig(s.blen)}};
          end else if (s.bpos - 3'h2 < ndig(s.blen)) begin
            n.dat = {24'h0, digit(s.blen, ndig(s.blen) - (s.bpos - 3'h2) - 3'h1)};
          end
          if (s.bpos != 3'h7) begin
            n.bpos = s.bpos + 3'h1;
          end
        end
        `SSR_A_MONCFG: n.dat = {15'h0, s.moncfg};
        `SSR_A_MONDAT: n.dat = {8'h00, s.mon_data};
        `SSR_A_STATUS: n.dat = {s.swp, 13'h0, mon_ok, s.ovf, s.run};
        default:       n.dat = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------------------------------
    // Sweep sequencer
    // ----------------------------------------------------------------
    // Sweep start source
    case (s.src)
      SRC_BUS: fire = s.pend;
      SRC_IMM: fire = 1'b1;
      SRC_EXT: fire = ext_edge;
      default: fire = (s.ivl_cnt == 29'h0);
    endcase
    case (s.st)
      ST_IDLE: begin
        if (wr && wb_adr_i[5:2] == `SSR_A_CTRL && wb_sel_i[0] &&
            wb_dat_i[`SSR_C_ARM] && s.size != 7'h00) begin
          n.run = 1'b1;
          n.swp = 16'h0000;
          n.ivl_cnt = 29'h0;
          n.pend = 1'b0;
          n.st = ST_WAIT;
        end else if (mon_ok) begin
          n.mreq = 1'b1;
          n.is_mon = 1'b1;
          n.chan = mon_chan;
          n.st = ST_MEAS;
        end
      end
      ST_WAIT: begin
        if (fire) begin
          n.ivl_cnt = s.ivl;
          n.tick = 17'h0_0000;
          n.pend = 1'b0;
          n.idx = 7'h00;
          n.chan = list[0];
          n.rly = 1'b1;
          n.dly = s.dly_set;
          n.stick = 17'h0_0000;
          n.st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (s.dly == 16'h0000) begin
          n.mreq = 1'b1;
          n.is_mon = 1'b0;
          n.st = ST_MEAS;
        end else if (s.stick == 17'(MS_CYC - 1)) begin
          n.stick = 17'h0_0000;
          n.dly = s.dly - 16'h0001;
        end else begin
          n.stick = s.stick + 17'h0_0001;
        end
      end
      ST_MEAS: begin
        if (meas_valid_i && s.is_mon) begin
          // Monitor reading kept apart from memory
          n.mon_data = meas_rdg_i.value;
          n.is_mon = 1'b0;
          n.st = s.run ? ST_WAIT : ST_IDLE;
        end else if (meas_valid_i) begin
          mem_we = 1'b1;
          if (s.idx + 7'h01 < s.size) begin
            n.idx = s.idx + 7'h01;
            n.chan = list[s.idx + 7'h01];
            n.dly = s.dly_set;
            n.stick = 17'h0_0000;
            n.st = ST_SETTLE;
          end else begin
            n.rly = 1'b0;
            n.swp = s.swp + 16'h0001;
            if (!s.cnt_inf && s.swp + 16'h0001 >= s.cnt_set) begin
              n.run = 1'b0;
            end
            if (mon_ok) begin
              n.mreq = 1'b1;
              n.is_mon = 1'b1;
              n.chan = mon_chan;
            end else begin
              n.st = n.run ? ST_WAIT : ST_IDLE;
            end
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (wr && wb_adr_i[5:2] == `SSR_A_CTRL && wb_sel_i[0] && wb_dat_i[`SSR_C_ABORT]) begin
      n.run = 1'b0;
      n.rly = 1'b0;
      n.is_mon = 1'b0;
      n.st = ST_IDLE;
    end

    // ----------------------------------------------------------------
    // Circular store pointers
    // ----------------------------------------------------------------
    // Erase advances tail only
    n.tail = erase ? wrap(17'(s.tail) + 17'h0_0001) : s.tail;
    cnt_t = erase ? s.count - 17'h0_0001 : s.count;
    if (erase && s.fidx != 17'h0_0000) begin
      n.fidx = n.fidx - 17'h0_0001;
    end
    if (mem_we) begin
      n.head = wrap(17'(s.head) + 17'h0_0001);
      if (cnt_t == `SSR_MEM_DEPTH) begin
        n.tail = wrap(17'(n.tail) + 17'h0_0001);
        n.ovf = 1'b1;
      end else begin
        cnt_t = cnt_t + 17'h0_0001;
      end
    end
    n.count = cnt_t;
  end

  // ----------------------------------------------------------------
  // State and memories
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.src <= SRC_TIM;
    end else if (ce_i) begin
      s <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_i && mem_we) begin
      mem[s.head] <= meas_rdg_i;
    end
    if (ce_i && !rst_i && list_we) begin
      list[s.size] <= wb_dat_i[9:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence store_seq;
    ce_i && s.st == ST_MEAS && !s.is_mon && meas_valid_i && !erase;
  endsequence

  store_alarm_a: assert property (store_seq |=> mem[$past(s.head)].alarm == $past(meas_rdg_i.alarm))
    else $error("stored alarm code differs");
  points_max_a: assert property (s.count <= `SSR_MEM_DEPTH)
    else $error("point count above limit");
  remove_erase_a: assert property (ce_i && erase && !mem_we |=> s.count == $past(s.count) - 17'h0_0001)
    else $error("erase did not drop count");
  fetch_keep_a: assert property (ce_i && rd && wb_adr_i[5:2] == `SSR_A_FETCH && !mem_we |=> $stable(s.tail) && $stable(s.count))
    else $error("fetch changed memory");
  drain_limit_a: assert property (ce_i && rd && wb_adr_i[5:2] == `SSR_A_DRAIN && s.rdlim == 17'h0_0000 |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("drain past its limit");
  blk_hash_a: assert property (ce_i && rd && wb_adr_i[5:2] == `SSR_A_BLK && s.bpos == 3'h0 |=> wb_dat_o[7:0] == `SSR_CH_HASH)
    else $error("block lacks hash");
  empty_list_a: assert property (ce_i && rd && wb_adr_i[5:2] == `SSR_A_LISTQ && s.size == 7'h00 && s.lpos == 7'h02 |=> wb_dat_o[7:0] == `SSR_CH_THREE)
    else $error("empty list block wrong");
  mon_nostore_a: assert property (ce_i && s.is_mon && meas_valid_i |-> !mem_we)
    else $error("monitor reading stored");
  mon_off_a: assert property ($fell(rst_i) |-> !s.moncfg[`SSR_M_EN] && s.src == SRC_TIM)
    else $error("reset defaults wrong");
  settle_wait_a: assert property ($rose(s.mreq) && !s.is_mon |-> $past(s.st) == ST_SETTLE && $past(s.dly) == 16'h0000)
    else $error("measured before settle");
  ovf_flag_a: assert property (ce_i && mem_we && s.count == `SSR_MEM_DEPTH && !erase |=> s.ovf && s.count == `SSR_MEM_DEPTH)
    else $error("overflow not flagged");
  sweep_stop_a: assert property (ce_i && s.st == ST_MEAS && !s.is_mon && meas_valid_i && !s.cnt_inf && s.idx + 7'h01 == s.size && s.swp + 16'h0001 >= s.cnt_set |=> !s.run)
    else $error("scan ran past count");

endmodule

`default_nettype wire

// ---- logic/ssr_defines.svh ----
/*
  Constants of the scan sequencer and reading store: register word
  indices, field positions, limits, timing and response characters.
  Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
*/
// Contract
// - Every stored reading keeps an alarm code: 0 none, 1 low, 2 high.
// - Point count reports readings held in memory, 0 to 50,000.
// - Remove returns readings oldest first and deletes them from memory.
// - Fetch copies stored readings out and deletes none of them.
// - Drain returns and deletes oldest first, up to an optional maximum; the code drains nothing until a maximum is written.
// - Block answers: hash, digit count, length digits, then payload bytes; the code returns zero words after a length of up to five digits.
// - Channel-list query of an empty list answers the fixed empty block.
// - Monitor readings never enter memory; scan first, one monitor per sweep.
// - Monitor off by default; without chosen channel, front panel one.
// - Monitor data query returns the bare reading value only.
// - Monitoring a totalizer never clears its count.
// - Mux channel monitored only with meter present and channel listed.
// - Scan list set from channel list; empty clears; arm starts scan.
// - Scan size query reports list length, 0 to 120.
// - Sweeps start on bus, immediate, external or timer; timer after reset.
// - Timer sweeps start the programmed interval apart, 0 to 359,999 s.
// - Scan stops after 1 to 50,000 sweeps, or never when infinite.
// - Infinite sweep count reads back as the fixed sentinel.
// - Settle delay between relay closure and measurement, 0 to 60 s.
// - On overflow flag it and overwrite the oldest readings.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ----------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define SSR_A_CTRL    4'h0
`define SSR_A_SRC     4'h1
`define SSR_A_IVL     4'h2
`define SSR_A_COUNT   4'h3
`define SSR_A_DELAY   4'h4
`define SSR_A_LIST    4'h5
`define SSR_A_LISTQ   4'h6
`define SSR_A_POINTS  4'h7
`define SSR_A_FETCH   4'h8
`define SSR_A_REMOVE  4'h9
`define SSR_A_DRAIN   4'hA
`define SSR_A_BLK     4'hB
`define SSR_A_MONCFG  4'hC
`define SSR_A_MONDAT  4'hD
`define SSR_A_STATUS  4'hE

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSR_C_ARM     0
`define SSR_C_TRIG    1
`define SSR_C_ABORT   2
`define SSR_C_OVFCLR  3
`define SSR_L_CLR     31
`define SSR_N_INF     31
`define SSR_M_SEL     12
`define SSR_M_EN      16
`define SSR_RD_VALID  31
`define SSR_RD_ALM    28

// ----------------------------------------------------------------
// Limits and codes
// ----------------------------------------------------------------
`define SSR_MEM_DEPTH  17'h0_C350
`define SSR_LIST_MAX   7'h78
`define SSR_CNT_INF_RD 32'hFFFF_FFFF
`define SSR_CH_HASH    8'h23
`define SSR_CH_ZERO    8'h30
`define SSR_CH_ONE     8'h31
`define SSR_CH_THREE   8'h33
`define SSR_CH_OPEN    8'h28
`define SSR_CH_AT      8'h40
`define SSR_CH_CLOSE   8'h29

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSR_CLK_NS     10
`define SSR_STEP_MS    1
`define SSR_MS_CYC     (`SSR_STEP_MS * 1000000 / `SSR_CLK_NS)

`endif

// ---- logic/ssr_pkg.sv ----
/*
  Types of the scan sequencer: states, trigger sources, channel kinds,
  the measurement carrier and the sequencer state record.
  Assumes ssr_defines.svh for all numeric constants.
*/
package ssr_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SETTLE, ST_MEAS} ssr_st_e;
  typedef enum logic [1:0] {SRC_BUS, SRC_IMM, SRC_EXT, SRC_TIM} ssr_src_e;
  typedef enum logic [1:0] {K_MUX, K_DIG, K_TOT, K_RSV} ssr_kind_e;

  typedef struct packed {
    logic [1:0]  alarm;
    logic [23:0] value;
  } ssr_rdg_s;

  typedef struct packed {
    ssr_st_e     st;
    logic        run;
    logic        pend;
    logic [6:0]  idx;
    logic [6:0]  size;
    logic [15:0] dly;
    logic [16:0] tick;
    logic [16:0] stick;
    logic [28:0] ivl_cnt;
    logic [28:0] ivl;
    logic [15:0] swp;
    logic [15:0] cnt_set;
    logic        cnt_inf;
    logic [15:0] dly_set;
    ssr_src_e    src;
    logic [16:0] moncfg;
    logic [23:0] mon_data;
    logic [15:0] head;
    logic [15:0] tail;
    logic [16:0] count;
    logic [16:0] fidx;
    logic [16:0] rdlim;
    logic        ovf;
    logic [19:0] blen;
    logic [2:0]  bpos;
    logic [6:0]  lpos;
    logic [2:0]  sync;
    logic        trg_lvl;
    logic        ack;
    logic [31:0] dat;
    logic        mreq;
    logic        is_mon;
    logic        rly;
    logic [9:0]  chan;
  } ssr_state_s;

endpackage

// ---- test/ssr_meas_model.sv ----
/*
  Measurement engine model: answers each request with one result pulse.
  Assumes requests are one-cycle pulses and never overlap.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_meas_model
  import ssr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic req_i,
  output logic      valid_o,
  output ssr_rdg_s  rdg_o
);
  logic [7:0] n_q;
  logic [1:0] alm_q;
  logic [1:0] wait_q;
  logic       busy_q;
  initial begin
    n_q = '0; alm_q = '0; wait_q = '0; busy_q = 1'b0; valid_o = 1'b0; rdg_o = '0;
  end
  // Result lines toggle when idle so a stale value is never mistaken for data
  always_ff @(posedge clk_i) begin
    valid_o <= 1'b0;
    rdg_o   <= ~rdg_o;
    if (req_i) begin
      busy_q <= 1'b1;
      wait_q <= 2'h3;
    end else if (busy_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (busy_q) begin
      busy_q  <= 1'b0;
      valid_o <= 1'b1;
      rdg_o   <= '{alarm: alm_q, value: 24'h00_0100 + 24'(n_q)};
      n_q     <= n_q + 8'h01;
      alm_q   <= (alm_q == 2'h2) ? 2'h0 : alm_q + 2'h1;
    end
  end
endmodule

`default_nettype wire

// ---- test/testbench.sv ----
/*
  Self-checking bench of the scan sequencer over classic Wishbone.
  Assumes the measurement model answers in program order.
*/
`include "ssr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench
  import ssr_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, mreq, mval, tkeep, relay, run, ack;
  logic ext, dmm;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [9:0]  mchan;
  ssr_rdg_s    rdg;
  int num_errors = 0;
  int check_count = 0;
  int n;
  logic [35:0] rows [14] = '{
    {4'h0, 32'h0}, {4'h1, 32'h3}, {4'h5, 32'h0}, {4'h7, 32'h0}, {4'hC, 32'h0},
    {4'hE, 32'h0}, {4'h6, 32'h23}, {4'h6, 32'h31}, {4'h6, 32'h33}, {4'h6, 32'h28},
    {4'h6, 32'h40}, {4'h6, 32'h29}, {4'h6, 32'h0}, {4'hF, 32'h0}};
  logic [7:0] blk [5] = '{8'h23, 8'h32, 8'h33, 8'h35, 8'h00};

  ssr_seq #(.MS_CYC(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trig_i(ext),
    .dmm_ok_i(dmm), .front_chan_i(10'h02A), .meas_valid_i(mval), .meas_rdg_i(rdg),
    .meas_req_o(mreq), .meas_chan_o(mchan), .tot_keep_o(tkeep),
    .relay_close_o(relay), .scan_run_o(run));
  ssr_meas_model i_meas (.clk_i(clk_i), .req_i(mreq), .valid_o(mval), .rdg_o(rdg));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {2'b00, a, 2'b00}; wdat <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (k == 50) begin num_errors++; $display("Error bus ack timeout"); close_out(); end
  endtask

  task automatic wreq();
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_i);
      if (mreq === 1'b1) break;
    end
    if (k == 300) begin num_errors++; $display("Error request timeout"); close_out(); end
  endtask

  function automatic logic [31:0] rd_word(input int k);
    return 32'h8000_0000 | (32'(k % 3) << 28) | (32'h0000_0100 + 32'(k));
  endfunction

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; wdat = '0;
    ext = 1'b0; dmm = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("run after reset", 32'h0, {31'h0, run});
    // ----------------------------------------------------------------
    // Reset values and empty list block
    // ----------------------------------------------------------------
    // reset values and the empty-list block stream
    foreach (rows[i]) begin
      wb(1'b0, rows[i][35:32], 32'h0);
      chk("reset row", rows[i][31:0], q);
    end
    $display("Test reset rows done");
    wb(1'b1, `SSR_A_BLK, 32'h0000_0023);
    foreach (blk[i]) begin
      wb(1'b0, `SSR_A_BLK, 32'h0);
      chk("block byte", {24'h0, blk[i]}, q);
    end
    wb(1'b1, `SSR_A_COUNT, 32'h8000_0000);
    wb(1'b0, `SSR_A_COUNT, 32'h0);
    chk("infinite count", `SSR_CNT_INF_RD, q);
    wb(1'b1, `SSR_A_COUNT, 32'h0000_0001);
    $display("Test block and count done");
    // ----------------------------------------------------------------
    // One sweep of two channels, then fetch, remove and drain
    // ----------------------------------------------------------------
    wb(1'b1, `SSR_A_LIST, 32'h0000_0065);
    wb(1'b1, `SSR_A_LIST, 32'h0000_0066);
    wb(1'b0, `SSR_A_LIST, 32'h0);
    chk("list size", 32'h2, q);
    wb(1'b1, `SSR_A_DELAY, 32'h0000_0002);
    wb(1'b1, `SSR_A_CTRL, 32'h0000_0001);
    for (n = 0; n < 100; n++) begin
      wb(1'b0, `SSR_A_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk("scan stopped", 32'h0, {31'h0, run});
    wb(1'b0, `SSR_A_POINTS, 32'h0);
    chk("points after sweep", 32'h2, q);
    for (n = 0; n < 3; n++) begin
      wb(1'b0, `SSR_A_FETCH, 32'h0);
      chk("fetch word", (n < 2) ? rd_word(n) : 32'h0, q);
    end
    wb(1'b0, `SSR_A_POINTS, 32'h0);
    chk("points after fetch", 32'h2, q);
    wb(1'b0, `SSR_A_REMOVE, 32'h0);
    chk("remove oldest", rd_word(0), q);
    wb(1'b0, `SSR_A_POINTS, 32'h0);
    chk("points after remove", 32'h1, q);
    wb(1'b1, `SSR_A_DRAIN, 32'h0000_0001);
    wb(1'b0, `SSR_A_DRAIN, 32'h0);
    chk("drain word", rd_word(1), q);
    wb(1'b0, `SSR_A_DRAIN, 32'h0);
    chk("drain empty", 32'h0, q);
    $display("Test sweep and memory done");
    // ----------------------------------------------------------------
    // Monitor: chosen channel, then front-panel channel
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, `SSR_A_MONCFG, (32'h1 << `SSR_M_EN) | (32'(K_DIG) << 10)
         | ((i == 0) ? ((32'h1 << `SSR_M_SEL) | 32'h9) : 32'h0));
      wreq();
      chk("monitor channel", (i == 0) ? 32'h9 : 32'h2A, {22'h0, mchan});
      chk("monitor keeps count", 32'h1, {31'h0, tkeep});
      wb(1'b1, `SSR_A_MONCFG, 32'h0);
      repeat (10) @(posedge clk_i);
      wb(1'b0, `SSR_A_POINTS, 32'h0);
      chk("points with monitor", 32'h0, q);
      wb(1'b0, `SSR_A_MONDAT, 32'h0);
      chk("monitor upper bits", 32'h0, {q[31:24], 24'h0});
    end
    $display("Test monitor done");
    close_out();
  end
endmodule

`default_nettype wire
